// File: design/tbp_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "tbp_defs.svh"

module tbp_port #(
    parameter int WIDE_W = 8,
    parameter int NARROW_W = 2
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // axi4-lite write address
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // wide port pullup controls
    output logic [WIDE_W-1:0] wide_port_pullup_on,
    // narrow port pins
    input wire logic [NARROW_W-1:0] narrow_pin_in,
    output logic [NARROW_W-1:0] narrow_pin_out,
    output logic [NARROW_W-1:0] narrow_pin_oe,
    // serial interface side
    input wire logic serial_iface_enable,
    input wire logic serial_txd,
    output logic serial_rxd
);

    // ============================================================
    // parameter checks
    if (WIDE_W < 1 || WIDE_W > 32) begin : g_bad_wide
        $error("wide port width must be 1 to 32");
    end
    if (NARROW_W != 2) begin : g_bad_narrow
        $error("narrow port must have exactly two pins");
    end

    localparam logic [NARROW_W-1:0] SERIAL_DRIVE = `TBP_SERIAL_DRIVE_MASK;

    // ============================================================
    // registers
    logic [WIDE_W-1:0] wide_pue_ff;
    logic [WIDE_W-1:0] nxt_wide_pue;
    logic [WIDE_W-1:0] wide_dir_ff;
    logic [WIDE_W-1:0] nxt_wide_dir;
    logic [NARROW_W-1:0] narrow_data_ff;
    logic [NARROW_W-1:0] nxt_narrow_data;
    logic [NARROW_W-1:0] narrow_dir_ff;
    logic [NARROW_W-1:0] nxt_narrow_dir;

    // bus state
    logic aw_held_ff;
    logic nxt_aw_held;
    logic [31:0] aw_addr_ff;
    logic w_held_ff;
    logic nxt_w_held;
    logic [31:0] w_data_ff;
    logic [3:0] w_strb_ff;
    logic awready_ff;
    logic wready_ff;
    logic bvalid_ff;
    logic nxt_bvalid;
    logic [1:0] bresp_ff;
    logic arready_ff;
    logic rvalid_ff;
    logic nxt_rvalid;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;

    // pin side state
    logic [WIDE_W-1:0] pullup_ff;
    logic [NARROW_W-1:0] pin_out_ff;
    logic [NARROW_W-1:0] pin_oe_ff;
    logic [NARROW_W-1:0] nxt_pin_out;
    logic [NARROW_W-1:0] nxt_pin_oe;
    logic rxd_ff;
    logic [NARROW_W-1:0] pin_sync;

    // ============================================================
    // pin input synchroniser
    tbp_sync2 #(
        .WIDTH(NARROW_W)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .d(narrow_pin_in),
        .q(pin_sync)
    );

    // ============================================================
    // address decode
    function automatic tbp_pkg::tbp_sel_t decode(input logic [31:0] addr);
        tbp_pkg::tbp_sel_t sel;
        case (addr)
            `TBP_OFF_WIDE_PUE: sel = tbp_pkg::TBP_SEL_WIDE_PUE;
            `TBP_OFF_WIDE_DIR: sel = tbp_pkg::TBP_SEL_WIDE_DIR;
            `TBP_OFF_NARROW_DATA: sel = tbp_pkg::TBP_SEL_NARROW_DATA;
            `TBP_OFF_NARROW_DIR: sel = tbp_pkg::TBP_SEL_NARROW_DIR;
            default: sel = tbp_pkg::TBP_SEL_NONE;
        endcase
        return sel;
    endfunction

    tbp_pkg::tbp_sel_t wr_sel;
    tbp_pkg::tbp_sel_t rd_sel;
    assign wr_sel = decode(aw_addr_ff);
    assign rd_sel = decode(s_axi_araddr);

    // ============================================================
    // write channel
    wire aw_fire = s_axi_awvalid & awready_ff;
    wire w_fire = s_axi_wvalid & wready_ff;
    // write only once both halves are held, so either order works
    wire do_write = aw_held_ff & w_held_ff & ~bvalid_ff;
    wire wr_lane0 = do_write & w_strb_ff[0];
    wire wr_miss = wr_sel == tbp_pkg::TBP_SEL_NONE;

    wire we_wide_pue = wr_lane0 & (wr_sel == tbp_pkg::TBP_SEL_WIDE_PUE);
    wire we_wide_dir = wr_lane0 & (wr_sel == tbp_pkg::TBP_SEL_WIDE_DIR);
    wire we_narrow_data = wr_lane0 & (wr_sel == tbp_pkg::TBP_SEL_NARROW_DATA);
    wire we_narrow_dir = wr_lane0 & (wr_sel == tbp_pkg::TBP_SEL_NARROW_DIR);

    assign nxt_aw_held = (aw_held_ff | aw_fire) & ~do_write;
    assign nxt_w_held = (w_held_ff | w_fire) & ~do_write;
    assign nxt_bvalid = do_write | (bvalid_ff & ~s_axi_bready);

    // upper write bits beyond each register's width are dropped here
    assign nxt_wide_pue = we_wide_pue ? w_data_ff[WIDE_W-1:0] : wide_pue_ff;
    assign nxt_wide_dir = we_wide_dir ? w_data_ff[WIDE_W-1:0] : wide_dir_ff;
    // latch takes the write even while the pin is an input
    assign nxt_narrow_data = we_narrow_data ? w_data_ff[NARROW_W-1:0] : narrow_data_ff;
    assign nxt_narrow_dir = we_narrow_dir ? w_data_ff[NARROW_W-1:0] : narrow_dir_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            aw_addr_ff <= 32'h0000_0000;
            w_data_ff <= 32'h0000_0000;
            w_strb_ff <= 4'h0;
        end else if (ce) begin
            aw_held_ff <= nxt_aw_held;
            w_held_ff <= nxt_w_held;
            if (aw_fire) begin
                aw_addr_ff <= s_axi_awaddr;
            end
            if (w_fire) begin
                w_data_ff <= s_axi_wdata;
                w_strb_ff <= s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= `TBP_RESP_OKAY;
        end else if (ce) begin
            awready_ff <= ~nxt_aw_held & ~nxt_bvalid;
            wready_ff <= ~nxt_w_held & ~nxt_bvalid;
            bvalid_ff <= nxt_bvalid;
            if (do_write) begin
                bresp_ff <= wr_miss ? `TBP_RESP_SLVERR : `TBP_RESP_OKAY;
            end
        end
    end

    // ============================================================
    // register file
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wide_pue_ff <= `TBP_RST_WIDE_PUE;
            wide_dir_ff <= `TBP_RST_WIDE_DIR;
            narrow_data_ff <= `TBP_RST_NARROW_DATA;
            narrow_dir_ff <= `TBP_RST_NARROW_DIR;
        end else if (ce) begin
            wide_pue_ff <= nxt_wide_pue;
            wide_dir_ff <= nxt_wide_dir;
            narrow_data_ff <= nxt_narrow_data;
            narrow_dir_ff <= nxt_narrow_dir;
        end
    end

    // ============================================================
    // read channel
    wire ar_fire = s_axi_arvalid & arready_ff;
    wire [NARROW_W-1:0] narrow_read;
    wire [31:0] rd_word;

    assign nxt_rvalid = ar_fire | (rvalid_ff & ~s_axi_rready);

    assign rd_word =
        (rd_sel == tbp_pkg::TBP_SEL_WIDE_PUE) ? {{(32-WIDE_W){1'b0}}, wide_pue_ff} :
        (rd_sel == tbp_pkg::TBP_SEL_WIDE_DIR) ? {{(32-WIDE_W){1'b0}}, wide_dir_ff} :
        (rd_sel == tbp_pkg::TBP_SEL_NARROW_DATA) ? {{(32-NARROW_W){1'b0}}, narrow_read} :
        (rd_sel == tbp_pkg::TBP_SEL_NARROW_DIR) ? {{(32-NARROW_W){1'b0}}, narrow_dir_ff} :
        32'h0000_0000;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= `TBP_RESP_OKAY;
        end else if (ce) begin
            arready_ff <= ~nxt_rvalid;
            rvalid_ff <= nxt_rvalid;
            if (ar_fire) begin
                rdata_ff <= rd_word;
                rresp_ff <= (rd_sel == tbp_pkg::TBP_SEL_NONE) ?
                    `TBP_RESP_SLVERR : `TBP_RESP_OKAY;
            end
        end
    end

    // ============================================================
    // narrow pin control, one slice per pin
    for (genvar i = 0; i < NARROW_W; i++) begin : g_pin
        // read view follows direction even under serial use
        assign narrow_read[i] = narrow_dir_ff[i] ? narrow_data_ff[i] : pin_sync[i];
        // serial owner ignores the direction bit entirely
        assign nxt_pin_oe[i] = serial_iface_enable ?
            SERIAL_DRIVE[i] : nxt_narrow_dir[i];
        assign nxt_pin_out[i] = serial_iface_enable ?
            (SERIAL_DRIVE[i] & serial_txd) : nxt_narrow_data[i];
    end

    // ============================================================
    // pin side registers
    // built from next values so pullups drop on the same edge
    // that a direction write lands, no window with both active
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pullup_ff <= '0;
            pin_out_ff <= '0;
            pin_oe_ff <= '0;
            rxd_ff <= 1'b1;
        end else if (ce) begin
            pullup_ff <= nxt_wide_pue & ~nxt_wide_dir;
            pin_out_ff <= nxt_pin_out;
            pin_oe_ff <= nxt_pin_oe;
            // idle high toward the receiver while not enabled
            rxd_ff <= serial_iface_enable ? pin_sync[`TBP_RX_BIT] : 1'b1;
        end
    end

    // ============================================================
    // outputs
    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign wide_port_pullup_on = pullup_ff;
    assign narrow_pin_out = pin_out_ff;
    assign narrow_pin_oe = pin_oe_ff;
    assign serial_rxd = rxd_ff;

endmodule // tbp_port

`default_nettype wire

// File: pkg/tbp_defs.svh
`ifndef TBP_DEFS_SVH
`define TBP_DEFS_SVH

// ============================================================
// register byte offsets
`define TBP_OFF_WIDE_PUE 32'h0000_0000
`define TBP_OFF_WIDE_DIR 32'h0000_0004
`define TBP_OFF_NARROW_DATA 32'h0000_0008
`define TBP_OFF_NARROW_DIR 32'h0000_000C

// ============================================================
// reset values
`define TBP_RST_WIDE_PUE 8'h00
`define TBP_RST_WIDE_DIR 8'h00
`define TBP_RST_NARROW_DATA 2'h0
`define TBP_RST_NARROW_DIR 2'h0

// ============================================================
// field positions and serial ownership
`define TBP_RX_BIT 1
`define TBP_TX_BIT 0
`define TBP_SERIAL_DRIVE_MASK 2'h1

// ============================================================
// bus answers
`define TBP_RESP_OKAY 2'h0
`define TBP_RESP_SLVERR 2'h2

`endif

// File: pkg/tbp_pkg.sv
package tbp_pkg;

    // ============================================================
    // register select
    typedef enum logic [2:0] {
        TBP_SEL_WIDE_PUE,
        TBP_SEL_WIDE_DIR,
        TBP_SEL_NARROW_DATA,
        TBP_SEL_NARROW_DIR,
        TBP_SEL_NONE
    } tbp_sel_t;

endpackage

// File: design/tbp_sync2.sv
`timescale 1ns/1ps
`default_nettype none

module tbp_sync2 #(
    parameter int WIDTH = 2
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // data
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    // ============================================================
    // two stages, first one feeds only the second
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] q_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_ff <= '0;
            q_ff <= '0;
        end else if (ce) begin
            meta_ff <= d;
            q_ff <= meta_ff;
        end
    end

    assign q = q_ff;

endmodule // tbp_sync2

`default_nettype wire

// File: verification/tbp_port_properties.sv
`timescale 1ns/1ps
`default_nettype none

module tbp_port_properties #(
    parameter int WIDE_W = 8,
    parameter int NARROW_W = 2
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pins
    input wire logic [WIDE_W-1:0] wide_port_pullup_on,
    input wire logic [NARROW_W-1:0] narrow_pin_out,
    input wire logic [NARROW_W-1:0] narrow_pin_oe,
    input wire logic serial_iface_enable,
    input wire logic serial_txd,
    input wire logic serial_rxd
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ============================================================
    // sequences
    sequence both_taken_s;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // pins seen now and one sample ago were set from the enable one and two samples back
    sequence gpio_owned_s;
        !$past(serial_iface_enable) && !$past(serial_iface_enable, 2);
    endsequence
    // ============================================================
    // checks
    pullup_write_only_a: assert property (!$rose(s_axi_bvalid) |-> $stable(wide_port_pullup_on))
        else $error("pullup moved without a write");
    pins_write_only_a: assert property (gpio_owned_s ##0 !$rose(s_axi_bvalid)
        |-> $stable(narrow_pin_oe) && $stable(narrow_pin_out))
        else $error("narrow pins moved without a write");
    serial_owns_a: assert property (serial_iface_enable
        |=> narrow_pin_oe == 2'h1 && narrow_pin_out[0] == $past(serial_txd))
        else $error("serial unit not driving narrow pins");
    rxd_idle_a: assert property (!serial_iface_enable |=> serial_rxd)
        else $error("receive line not idle");
    // one cycle to apply the held pair, then the response flop
    write_answer_a: assert property (both_taken_s |-> ##2 s_axi_bvalid)
        else $error("write response late");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read bits set");
endmodule // tbp_port_properties

bind tbp_port tbp_port_properties #(.WIDE_W(WIDE_W), .NARROW_W(NARROW_W))
    tbp_port_properties_inst (.*);

`default_nettype wire

// File: verification/tbp_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

module tbp_pin_model (
    // pad drive from the port
    input wire logic [1:0] pin_oe,
    input wire logic [1:0] pin_out,
    // outside source
    input wire logic [1:0] ext_level,
    // level on the pads
    output logic [1:0] pin_level
);
    // no pull on these pads, so an undriven pad follows the outside source
    assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule // tbp_pin_model

`default_nettype wire

// File: verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "tbp_defs.svh"

module testbench;
    logic clk = 0, rst = 1, ce = 1;
    logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] wide_port_pullup_on;
    logic [1:0] narrow_pin_in, narrow_pin_out, narrow_pin_oe, ext_level = 2'h2;
    logic serial_iface_enable = 0, serial_txd = 1, serial_rxd;
    int fail_count = 0, check_count = 0;

    always #50 clk = ~clk;
    tbp_port tbp_port_inst (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wide_port_pullup_on(wide_port_pullup_on),
        .narrow_pin_in(narrow_pin_in),
        .narrow_pin_out(narrow_pin_out),
        .narrow_pin_oe(narrow_pin_oe),
        .serial_iface_enable(serial_iface_enable),
        .serial_txd(serial_txd),
        .serial_rxd(serial_rxd)
    );
    tbp_pin_model tbp_pin_model_inst (.pin_oe(narrow_pin_oe), .pin_out(narrow_pin_out),
        .ext_level(ext_level), .pin_level(narrow_pin_in));
    // ============================================================
    // helpers
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            fail_count++;
            $display("Error at %0t: seen %0h expected %0h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 0;
        chk(s_axi_bresp, er);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 0;
        chk(s_axi_rdata, e);
        chk(s_axi_rresp, er);
    endtask
    // ============================================================
    // scenarios
    task automatic t_reset;
        rd(`TBP_OFF_WIDE_PUE, 0, `TBP_RESP_OKAY);
        rd(`TBP_OFF_WIDE_DIR, 0, `TBP_RESP_OKAY);
        rd(`TBP_OFF_NARROW_DIR, 0, `TBP_RESP_OKAY);
        chk(narrow_pin_oe, 0);
    endtask
    task automatic t_pullup;
        wr(`TBP_OFF_WIDE_PUE, 32'hFF, `TBP_RESP_OKAY);
        chk(wide_port_pullup_on, 32'hFF);
        wr(`TBP_OFF_WIDE_DIR, 32'h0F, `TBP_RESP_OKAY);
        chk(wide_port_pullup_on, 32'hF0);
        rd(`TBP_OFF_WIDE_DIR, 32'h0F, `TBP_RESP_OKAY);
        wr(`TBP_OFF_WIDE_PUE, 32'h0, `TBP_RESP_OKAY);
        chk(wide_port_pullup_on, 0);
    endtask
    task automatic t_narrow;
        wr(`TBP_OFF_NARROW_DATA, 32'h1, `TBP_RESP_OKAY);
        rd(`TBP_OFF_NARROW_DATA, 32'h2, `TBP_RESP_OKAY);
        wr(`TBP_OFF_NARROW_DIR, 32'h3, `TBP_RESP_OKAY);
        chk({narrow_pin_oe, narrow_pin_out}, 32'hD);
        rd(`TBP_OFF_NARROW_DATA, 32'h1, `TBP_RESP_OKAY);
        wr(`TBP_OFF_NARROW_DATA, 32'hFFFFFFFF, `TBP_RESP_OKAY);
        rd(`TBP_OFF_NARROW_DATA, 32'h3, `TBP_RESP_OKAY);
        ext_level <= 2'h0;
        wr(`TBP_OFF_NARROW_DIR, 32'h1, `TBP_RESP_OKAY);
        rd(`TBP_OFF_NARROW_DATA, 32'h1, `TBP_RESP_OKAY);
    endtask
    task automatic t_serial;
        wr(`TBP_OFF_NARROW_DIR, 32'h2, `TBP_RESP_OKAY);
        serial_iface_enable <= 1;
        serial_txd <= 0;
        repeat (2) @(posedge clk);
        chk({narrow_pin_oe, narrow_pin_out[0]}, 32'h2);
        chk(serial_rxd, 0);
        ext_level <= 2'h2;
        serial_txd <= 1;
        repeat (5) @(posedge clk);
        chk({serial_rxd, narrow_pin_out[0]}, 32'h3);
        serial_txd <= 0;
        repeat (4) @(posedge clk);
        rd(`TBP_OFF_NARROW_DATA, 32'h2, `TBP_RESP_OKAY);
        serial_iface_enable <= 0;
        repeat (2) @(posedge clk);
        chk({narrow_pin_oe, narrow_pin_out}, 32'hB);
        chk(serial_rxd, 1);
    endtask
    task automatic t_unmapped;
        wr(32'h10, 32'hFF, `TBP_RESP_SLVERR);
        rd(32'h10, 0, `TBP_RESP_SLVERR);
    endtask
    // ============================================================
    // main
    initial begin
        repeat (4) @(posedge clk);
        rst <= 0;
        t_reset;
        t_pullup;
        t_narrow;
        t_serial;
        t_unmapped;
        end_sim;
    end
    // about 85 cycles expected; hang cut at 5000
    initial begin
        #500000;
        fail_count++;
        end_sim;
    end
endmodule // testbench

`default_nettype wire
